// [logic/rxg_pkg.sv]
package rxg_pkg;
  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_SEL = 8'h17; // receiver_input_and_guard
  localparam logic [7:0] ADDR_THR = 8'h18; // decoder_thresholds
  localparam logic [7:0] ADDR_STATUS = 8'h30; // sticky events, write one clears
  localparam logic [7:0] ADDR_MASK = 8'h31; // interrupt mask
  localparam logic [7:0] SEL_RESET = 8'h84;
  localparam logic [7:0] THR_RESET = 8'h84;
  localparam logic [7:0] MASK_RESET = 8'h00;
  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int SEL_INPUT_HI = 7;
  localparam int SEL_INPUT_LO = 6;
  localparam int SEL_WAIT_HI = 5;
  localparam int SEL_WAIT_LO = 0;
  localparam int THR_MIN_HI = 7;
  localparam int THR_MIN_LO = 4;
  localparam int THR_RSV_BIT = 3;
  localparam int THR_COLL_HI = 2;
  localparam int THR_COLL_LO = 0;
  localparam logic [7:0] THR_WRITE_MASK = 8'hf7; // reserved bit never stored
  // status bits
  localparam int ST_RX_ON = 0;
  localparam int ST_COLL = 1;
  localparam int ST_WEAK = 2;
  localparam int ST_WIDTH = 3;
  // ----------------------------------------------------------------
  // input select codes and timing
  // ----------------------------------------------------------------
  localparam logic [1:0] IN_LOW = 2'h0;
  localparam logic [1:0] IN_PIN_ENV = 2'h1;
  localparam logic [1:0] IN_ANALOG = 2'h2;
  localparam logic [1:0] IN_PIN_MOD = 2'h3;
  localparam int CLOCK_HZ = 25000000;
  localparam int BIT_RATE_HZ = 106000; // default bit-clock rate
  localparam int BIT_DIV = CLOCK_HZ / BIT_RATE_HZ; // cycles per bit-clock, rounded down
  // guard sequencer states
  typedef enum logic [1:0] {GUARD_IDLE, GUARD_ARMED, GUARD_COUNT, GUARD_RX_ON} rxg_state_t;
endpackage : rxg_pkg

// [logic/rxg_receiver_guard.sv]
`timescale 1ns/1ps
module rxg_receiver_guard #(
  parameter int BIT_CYCLES = rxg_pkg::BIT_DIV
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic signal_input_pin,
  input wire logic analog_mod,
  input wire logic cmd_start,
  input wire logic cmd_is_receive,
  input wire logic cmd_stop,
  input wire logic active_mode,
  input wire logic tx_last_pulse,
  input wire logic ext_field_on,
  input wire logic bit_valid,
  input wire logic [3:0] half_strong,
  input wire logic [3:0] half_weak,
  output logic rx_enable,
  output logic rx_serial,
  output logic bit_accept,
  output logic bit_collision,
  output logic irq
);
  import rxg_pkg::*;

  // refuse a divider that the 16-bit tick counter cannot serve
  if (BIT_CYCLES < 2 || BIT_CYCLES > 65535) begin : g_bad_bit_cycles
    $error("BIT_CYCLES out of range");
  end

  localparam logic [15:0] TICK_LAST = 16'(BIT_CYCLES - 1);

  logic pin_sync;
  logic [7:0] sel_reg;
  logic [7:0] thr_reg;
  logic [ST_WIDTH-1:0] status;
  logic [ST_WIDTH-1:0] mask;
  logic [7:0] next_sel_reg;
  logic [7:0] next_thr_reg;
  logic [ST_WIDTH-1:0] next_status;
  logic [ST_WIDTH-1:0] next_mask;
  logic [7:0] next_reg_rdata;
  logic next_irq;
  logic [15:0] tick_cnt;
  logic [15:0] next_tick_cnt;
  logic bit_tick;
  rxg_state_t state;
  rxg_state_t next_state;
  logic [5:0] guard_cnt;
  logic [5:0] next_guard_cnt;
  logic next_rx_enable;
  logic next_rx_serial;
  logic next_bit_accept;
  logic next_bit_collision;
  logic [1:0] in_sel;
  logic [5:0] wait_bits;
  logic [3:0] min_level;
  logic [2:0] coll_level;
  logic routed;
  logic strong_ok;
  logic coll_hit;
  logic [6:0] weak_scaled;
  logic [6:0] strong_scaled;

  // ----------------------------------------------------------------
  // pin synchroniser
  // ----------------------------------------------------------------
  rxg_sync2 u_pin_sync (
    .clock(clock),
    .rst_b(rst_b),
    .async_in(signal_input_pin),
    .sync_out(pin_sync)
  );

  assign in_sel = sel_reg[SEL_INPUT_HI:SEL_INPUT_LO];
  assign wait_bits = sel_reg[SEL_WAIT_HI:SEL_WAIT_LO];
  assign min_level = thr_reg[THR_MIN_HI:THR_MIN_LO];
  assign coll_level = thr_reg[THR_COLL_HI:THR_COLL_LO];

  // ----------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------
  // writes, sticky status, read mux
  always_comb begin
    next_sel_reg = sel_reg;
    next_thr_reg = thr_reg;
    next_mask = mask;
    next_status = status;
    next_reg_rdata = 8'h00;
    if (reg_wr) begin
      case (reg_addr)
        ADDR_SEL: next_sel_reg = reg_wdata;
        ADDR_THR: next_thr_reg = reg_wdata & THR_WRITE_MASK;
        ADDR_MASK: next_mask = reg_wdata[ST_WIDTH-1:0];
        ADDR_STATUS: next_status = status & ~reg_wdata[ST_WIDTH-1:0];
        default: ;
      endcase
    end
    // set wins over a clear in the same cycle
    if (next_rx_enable && !rx_enable) begin
      next_status[ST_RX_ON] = 1'b1;
    end
    if (next_bit_collision) begin
      next_status[ST_COLL] = 1'b1;
    end
    if (bit_valid && rx_enable && !strong_ok) begin
      next_status[ST_WEAK] = 1'b1;
    end
    if (reg_rd) begin
      case (reg_addr)
        ADDR_SEL: next_reg_rdata = sel_reg;
        ADDR_THR: next_reg_rdata = thr_reg & THR_WRITE_MASK;
        ADDR_STATUS: next_reg_rdata = {5'h00, status};
        ADDR_MASK: next_reg_rdata = {5'h00, mask};
        default: next_reg_rdata = 8'h00;
      endcase
    end
    next_irq = |(next_status & next_mask);
  end

  // register state
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      sel_reg <= SEL_RESET;
      thr_reg <= THR_RESET;
      status <= '0;
      mask <= MASK_RESET[ST_WIDTH-1:0];
      reg_rdata <= 8'h00;
      irq <= 1'b0;
    end else begin
      sel_reg <= next_sel_reg;
      thr_reg <= next_thr_reg;
      status <= next_status;
      mask <= next_mask;
      reg_rdata <= next_reg_rdata;
      irq <= next_irq;
    end
  end

  // ----------------------------------------------------------------
  // bit-clock divider
  // ----------------------------------------------------------------
  always_comb begin
    bit_tick = (tick_cnt == TICK_LAST);
    next_tick_cnt = bit_tick ? 16'h0000 : tick_cnt + 16'h0001;
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      tick_cnt <= 16'h0000;
    end else begin
      tick_cnt <= next_tick_cnt;
    end
  end

  // ----------------------------------------------------------------
  // frame guard sequencer
  // ----------------------------------------------------------------
  // command start, trigger, count, enable
  always_comb begin
    next_state = state;
    next_guard_cnt = guard_cnt;
    case (state)
      GUARD_IDLE: begin
        if (cmd_start && cmd_is_receive) begin
          next_state = GUARD_RX_ON;
        end else if (cmd_start) begin
          next_state = GUARD_ARMED;
        end
      end
      GUARD_ARMED: begin
        if ((!active_mode && tx_last_pulse) || (active_mode && ext_field_on)) begin
          next_guard_cnt = wait_bits;
          next_state = (wait_bits == 6'h00) ? GUARD_RX_ON : GUARD_COUNT;
        end
      end
      GUARD_COUNT: begin
        if (bit_tick) begin
          if (guard_cnt == 6'h00) begin
            next_state = GUARD_RX_ON;
          end else begin
            next_guard_cnt = guard_cnt - 6'h01;
          end
        end
      end
      GUARD_RX_ON: ;
      default: next_state = GUARD_IDLE;
    endcase
    if (cmd_stop) begin
      next_state = GUARD_IDLE;
    end
    next_rx_enable = (next_state == GUARD_RX_ON);
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state <= GUARD_IDLE;
      guard_cnt <= 6'h00;
      rx_enable <= 1'b0;
    end else begin
      state <= next_state;
      guard_cnt <= next_guard_cnt;
      rx_enable <= next_rx_enable;
    end
  end

  // ----------------------------------------------------------------
  // input routing and decoder thresholds
  // ----------------------------------------------------------------
  always_comb begin
    case (in_sel)
      IN_LOW: routed = 1'b0;
      IN_PIN_ENV: routed = pin_sync;
      IN_ANALOG: routed = analog_mod;
      IN_PIN_MOD: routed = pin_sync;
      default: routed = 1'b0;
    endcase
    // guard interval ignores everything at the input
    next_rx_serial = rx_enable && routed;
    strong_ok = (half_strong >= min_level);
    weak_scaled = {half_weak, 3'h0};
    strong_scaled = 7'(half_strong * coll_level);
    coll_hit = (weak_scaled >= strong_scaled);
    next_bit_accept = bit_valid && rx_enable && strong_ok;
    next_bit_collision = next_bit_accept && coll_hit;
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rx_serial <= 1'b0;
      bit_accept <= 1'b0;
      bit_collision <= 1'b0;
    end else begin
      rx_serial <= next_rx_serial;
      bit_accept <= next_bit_accept;
      bit_collision <= next_bit_collision;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  chk_sel_reset: assert property (@(posedge clock) $rose(rst_b) |-> sel_reg == 8'h84)
    else $error("select register reset value wrong");
  chk_thr_reset: assert property (@(posedge clock) $rose(rst_b) |-> thr_reg == 8'h84)
    else $error("threshold register reset value wrong");
  chk_route_low: assert property (@(posedge clock) disable iff (!rst_b)
    in_sel == 2'h0 |=> !rx_serial)
    else $error("constant low input not low");
  chk_route_analog: assert property (@(posedge clock) disable iff (!rst_b)
    rx_enable && in_sel == 2'h2 |=> rx_serial == $past(analog_mod))
    else $error("analog input not routed");
  chk_guard_quiet: assert property (@(posedge clock) disable iff (!rst_b)
    !rx_enable |=> !rx_serial)
    else $error("input passed during guard time");
  chk_receive_nowait: assert property (@(posedge clock) disable iff (!rst_b)
    state == GUARD_IDLE && cmd_start && cmd_is_receive && !cmd_stop |=> rx_enable)
    else $error("receive command delayed");
  chk_cmd_waits: assert property (@(posedge clock) disable iff (!rst_b)
    state == GUARD_IDLE && cmd_start && !cmd_is_receive |=> !rx_enable)
    else $error("other command skipped guard");
  chk_passive_start: assert property (@(posedge clock) disable iff (!rst_b)
    state == GUARD_ARMED && !active_mode && tx_last_pulse && wait_bits != 6'h00 && !cmd_stop
    |=> state == GUARD_COUNT && guard_cnt == $past(wait_bits))
    else $error("passive guard start wrong");
  chk_active_start: assert property (@(posedge clock) disable iff (!rst_b)
    state == GUARD_ARMED && active_mode && ext_field_on && wait_bits != 6'h00 && !cmd_stop
    |=> state == GUARD_COUNT)
    else $error("active guard start wrong");
  chk_guard_end: assert property (@(posedge clock) disable iff (!rst_b)
    state == GUARD_COUNT && guard_cnt == 6'h00 && bit_tick && !cmd_stop |=> rx_enable)
    else $error("receiver not enabled after guard");
  chk_min_level: assert property (@(posedge clock) disable iff (!rst_b)
    bit_valid && half_strong < min_level |=> !bit_accept && !bit_collision)
    else $error("weak signal evaluated");
  chk_coll_flag: assert property (@(posedge clock) disable iff (!rst_b)
    bit_valid && rx_enable && half_strong >= min_level
    |=> bit_accept && bit_collision == ({3'h0, $past(half_weak)} * 7'h08 >=
    {3'h0, $past(half_strong)} * {4'h0, $past(coll_level)}))
    else $error("collision flag wrong");
  chk_rsv_zero: assert property (@(posedge clock) disable iff (!rst_b)
    reg_rd && reg_addr == ADDR_THR |=> reg_rdata[3] == 1'b0)
    else $error("reserved bit reads one");
  chk_irq_level: assert property (@(posedge clock) disable iff (!rst_b)
    irq == |(status & mask))
    else $error("interrupt output mismatch");
endmodule : rxg_receiver_guard

// [logic/rxg_sync2.sv]
`timescale 1ns/1ps
// two flip-flop synchroniser for a pin input
module rxg_sync2 (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic async_in,
  output logic sync_out
);
  logic meta;

  // ----------------------------------------------------------------
  // first stage read only by the second
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      meta <= 1'b0;
      sync_out <= 1'b0;
    end else begin
      meta <= async_in;
      sync_out <= meta;
    end
  end
endmodule : rxg_sync2

// [test/rxg_card_model.sv]
`timescale 1ns/1ps
// -----------------------------------------------
// card side: field levels and decoded bit amplitudes
// -----------------------------------------------
module rxg_card_model (
  input wire logic clock,
  output logic analog_mod,
  output logic signal_input_pin,
  output logic bit_valid,
  output logic [3:0] half_strong,
  output logic [3:0] half_weak
);
  // quiet field at start
  initial begin
    analog_mod = 1'b0;
    signal_input_pin = 1'b0;
    bit_valid = 1'b0;
    half_strong = 4'h0;
    half_weak = 4'h0;
  end
  // pin and analog path carry opposite levels so routing is visible
  task automatic drive(input logic v);
    @(posedge clock);
    signal_input_pin <= v;
    analog_mod <= ~v;
  endtask : drive
  // one bit, then amplitudes go stale (inverted) so nothing lingers
  task automatic send_bit(input logic [3:0] s, input logic [3:0] w);
    @(posedge clock);
    bit_valid <= 1'b1;
    half_strong <= s;
    half_weak <= w;
    @(posedge clock);
    bit_valid <= 1'b0;
    half_strong <= ~s;
    half_weak <= ~w;
  endtask : send_bit
endmodule : rxg_card_model

// [test/tb.sv]
`timescale 1ns/1ps
module tb;
  import rxg_pkg::*;
  logic clock, rst_b, reg_wr, reg_rd, cmd_start, cmd_is_receive, cmd_stop;
  logic active_mode, tx_last_pulse, ext_field_on, analog_mod, signal_input_pin;
  logic bit_valid, rx_enable, rx_serial, bit_accept, bit_collision, irq;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic [3:0] half_strong, half_weak;
  logic [9:0] bits [4] = '{10'h257, 10'h1d4, 10'h252, 10'h213};
  int mismatches, check_count;
  // -----------------------------------------------
  // design and card
  // -----------------------------------------------
  rxg_receiver_guard #(.BIT_CYCLES(4)) dut (.clock, .rst_b, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .signal_input_pin, .analog_mod, .cmd_start,
    .cmd_is_receive, .cmd_stop, .active_mode, .tx_last_pulse, .ext_field_on,
    .bit_valid, .half_strong, .half_weak, .rx_enable, .rx_serial, .bit_accept,
    .bit_collision, .irq);
  rxg_card_model card (.clock, .analog_mod, .signal_input_pin, .bit_valid,
    .half_strong, .half_weak);
  // 25 mhz clock
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  // -----------------------------------------------
  // helpers
  // -----------------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : final_report
  task automatic done(input string s);
    $display("test %s finished", s);
  endtask : done
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask : wr
  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1;
    check(reg_rdata, exp);
  endtask : rd
  // start a command, fire the trigger, time the guard interval
  task automatic guard(input logic [5:0] n, input logic rcv, input logic act);
    int c;
    c = 0;
    wr(ADDR_SEL, {IN_ANALOG, n});
    @(posedge clock);
    cmd_stop <= 1'b1;
    @(posedge clock);
    cmd_stop <= 1'b0;
    cmd_start <= 1'b1;
    cmd_is_receive <= rcv;
    active_mode <= act;
    ext_field_on <= 1'b0;
    @(posedge clock);
    cmd_start <= 1'b0;
    tx_last_pulse <= ~rcv & ~act;
    ext_field_on <= ~rcv & act;
    #1;
    if (rcv) check(8'(rx_enable), 8'h01);
    while (!rcv && !rx_enable && c < 300) begin
      @(posedge clock);
      tx_last_pulse <= 1'b0;
      #1;
      c++;
      if (!rx_enable) check(8'(rx_serial), 8'h00);
    end
    if (!rcv) check(8'(c >= (n == 0 ? 1 : 4 * n + 2) && c <= (n == 0 ? 1 : 4 * n + 5)), 8'h01);
    if (c >= 300) final_report();
  endtask : guard
  // -----------------------------------------------
  // main sequence
  // -----------------------------------------------
  initial begin
    {rst_b, reg_wr, reg_rd, cmd_start, cmd_is_receive, cmd_stop} = 6'h00;
    {active_mode, tx_last_pulse, ext_field_on} = 3'h0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    repeat (8) @(posedge clock);
    rst_b <= 1'b1;
    rd(ADDR_SEL, SEL_RESET);
    rd(ADDR_THR, THR_RESET);
    rd(ADDR_STATUS, 8'h00);
    rd(ADDR_MASK, MASK_RESET);
    wr(ADDR_THR, 8'hff);
    rd(ADDR_THR, 8'hf7);
    wr(ADDR_THR, THR_RESET);
    wr(8'h20, 8'h5a);
    rd(8'h20, 8'h00);
    done("registers");
    card.drive(1'b0);
    guard(6'd2, 1'b0, 1'b0);
    guard(6'd0, 1'b0, 1'b1);
    guard(6'd5, 1'b0, 1'b1);
    guard(6'h3f, 1'b1, 1'b0);
    done("guard");
    for (int k = 0; k < 4; k++) begin
      for (int v = 0; v < 2; v++) begin
        wr(ADDR_SEL, {2'(k), 6'h04}); // code 11 reads the synchronised pin, same as code 01
        card.drive(1'(v));
        repeat (5) @(posedge clock);
        #1;
        check(8'(rx_serial), 8'(k == 0 ? 0 : (k == 2 ? 1 - v : v)));
      end
    end
    done("routing");
    for (int i = 0; i < 4; i++) begin
      card.send_bit(bits[i][9:6], bits[i][5:2]);
      #1;
      check(8'({bit_accept, bit_collision}), 8'(bits[i][1:0]));
    end
    done("decoder");
    rd(ADDR_STATUS, 8'h07);
    wr(ADDR_MASK, 8'h02);
    repeat (2) @(posedge clock);
    #1;
    check(8'(irq), 8'h01);
    wr(ADDR_STATUS, 8'h02);
    repeat (2) @(posedge clock);
    #1;
    check(8'(irq), 8'h00);
    rd(ADDR_STATUS, 8'h05);
    done("interrupt");
    final_report();
  end
endmodule : tb
